/* hw/phy_mgmt_regs.svh */
// Constants of the two-port management register bank.
// Assumes inclusion by bare name from design files under hw/.
//
// How it works
// - Far-end loop returns other port's receive stream
// - Far loop bit aliases control bit 14
// - Near-end loop turns receive around same port
// - Near loop bit aliases special bit 1
// - Port addresses 1 and 2, reprogrammable globally
// - Only indices 0-5, 0x1d, 0x1f implemented
// - Control speed, negotiation, power, restart, duplex bits
// - Control bit 5 picks crossover algorithm
// - Control bits 4,3 force wiring, disable crossover
// - Control bits 2,1,0 fault, transmit, LED disables
// - Control bits 15,10,7,6 always read zero
// - Status capability bits fixed, unused bits zero
// - Status shows negotiation done and link up
// - Status bit 4 shows far-end fault
// - Status bit 3 tracks negotiation enable
// - Management fields share switch register storage
`ifndef PHY_MGMT_REGS_SVH
`define PHY_MGMT_REGS_SVH

// Management register indices
`define IDX_CTRL 5'h00
`define IDX_STAT 5'h01
`define IDX_IDH 5'h02
`define IDX_IDL 5'h03
`define IDX_ADV 5'h04
`define IDX_PART 5'h05
`define IDX_CABLE 5'h1d
`define IDX_SPEC 5'h1f

// Switch-side byte map
`define SW_GLOBAL 8'h0f
`define SW_P1_BASE 8'h1a
`define SW_P2_BASE 8'h2a
`define SW_SPAN 8'h06
`define SW_R26 3'h0
`define SW_R27 3'h1
`define SW_R28 3'h2
`define SW_R29 3'h3
`define SW_R30 3'h4
`define SW_R31 3'h5

// Reset values and byte 26 write mask
`define RST_GLOBAL 8'h08
`define RST_R26 8'h00
`define RST_R28 8'h9f
`define RST_R29 8'h00
`define RST_ALT 1'b1
`define R26_MASK 8'h12

// Field positions in switch bytes
`define R26_CABLE 4
`define R26_NEAR 1
`define R28_NEG_EN 7
`define R28_F100 6
`define R28_FDUP 5
`define R29_RESTART 5
`define GLB_ADDR_LSB 3

// Frame constants
`define PRE_LEN 6'd32
`define OP_RD 2'b10
`define OP_WR 2'b01

`endif

/* hw/phy_mgmt_pkg.sv */
// Types shared by the management bank and its port slices.
// Assumes no other package is needed.
package phy_mgmt_pkg;

	// Status from one PHY core, same clock
	typedef struct packed {
		logic link_up;
		logic neg_done;
		logic [4:0] partner;
		logic far_fault;
		logic restart_begun;
		logic cable_done;
		logic [1:0] cable_result;
		logic cable_short;
		logic [8:0] cable_count;
	} phy_stat_type;

	// Controls toward one PHY core
	typedef struct packed {
		logic force_100;
		logic negotiation_enable;
		logic power_down;
		logic negotiation_restart;
		logic full_duplex;
		logic alt_crossover_algorithm;
		logic force_straight_wiring;
		logic crossover_off;
		logic far_fault_off;
		logic tx_off;
		logic led_off;
		logic far_loop;
		logic near_loop;
		logic cable_start;
		logic [4:0] advertise;
	} phy_ctrl_type;

	// Switch-side byte access
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sw_bus_type;

	// Decoded write into one port slice
	typedef struct packed {
		logic wr;
		logic [4:0] idx;
		logic [15:0] wdata;
	} mgmt_req_type;

	typedef struct packed {
		logic wr;
		logic [2:0] idx;
		logic [7:0] wdata;
	} sw_req_type;

	// Management frame walker
	typedef enum logic [2:0] {
		FR_PREAMBLE,
		FR_START,
		FR_OPCODE,
		FR_PHYADDR,
		FR_REGADDR,
		FR_TURN,
		FR_WDATA,
		FR_RDATA
	} frame_state_type;

endpackage : phy_mgmt_pkg

/* hw/pin_sync3.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous inputs; output follows once stages 2 and 3 agree.
module pin_sync3 #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_r; // Metastable stage, read by s2 only
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	wire [W-1:0] agree = ~(s2_r ^ s3_r); // Stages 2 and 3 match

	// Chain and filtered output
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_o <= '0;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_o <= (agree & s3_r) | (~agree & q_o);
		end
	end
endmodule : pin_sync3

/* hw/port_phy_regs.sv */
// Storage and register views of one copper port.
// Assumes writes arrive decoded to this port, on clk_i.
`include "phy_mgmt_regs.svh"
module port_phy_regs
	import phy_mgmt_pkg::*;
#(
	parameter logic [15:0] ID_HIGH = 16'h1a2b, // Arbitrary value
	parameter logic [15:0] ID_LOW = 16'h3c4d // Arbitrary value
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire mgmt_req_type mg_i,
	input wire sw_req_type sw_i,
	input wire phy_stat_type stat_i,
	output logic [15:0] mg_rdata_o,
	output logic [7:0] sw_rdata_o,
	output phy_ctrl_type ctrl_o
);
	logic [7:0] r26_r; // Cable start, near loop
	logic [7:0] r28_r; // Negotiation, speed, advertise
	logic [7:0] r29_r; // Loop, power, restart, disables
	logic alt_r; // Crossover algorithm
	wire [15:0] wd = mg_i.wdata;

	// Write decode; management wins a same-cycle clash
	wire mg_ctl = mg_i.wr && (mg_i.idx == `IDX_CTRL);
	wire mg_adv = mg_i.wr && (mg_i.idx == `IDX_ADV);
	wire mg_cab = mg_i.wr && (mg_i.idx == `IDX_CABLE);
	wire mg_spc = mg_i.wr && (mg_i.idx == `IDX_SPEC);
	wire sw26 = sw_i.wr && (sw_i.idx == `SW_R26);
	wire sw28 = sw_i.wr && (sw_i.idx == `SW_R28);
	wire sw29 = sw_i.wr && (sw_i.idx == `SW_R29);
	wire sw31 = sw_i.wr && (sw_i.idx == `SW_R31);

	// One store, two maps
	wire [7:0] r28_nxt = mg_ctl ? {wd[12], wd[13], wd[8], r28_r[4:0]} :
		mg_adv ? {r28_r[7:5], wd[10], wd[8:5]} : sw28 ? sw_i.wdata : r28_r;
	wire [7:0] r29_wr = mg_ctl ? {wd[0], wd[1], wd[9], wd[2], wd[11], wd[3], wd[4], wd[14]} : sw_i.wdata;
	wire r29_we = mg_ctl | sw29;
	wire [7:0] r29_base = r29_we ? r29_wr : r29_r;
	wire rst_clr = stat_i.restart_begun & ~(r29_we & r29_wr[`R29_RESTART]); // Set wins
	wire [7:0] r29_nxt = r29_base & ~(8'(rst_clr) << `R29_RESTART);
	wire [7:0] r26_wr = mg_cab ? {r26_r[7:5], wd[15], r26_r[3:0]} :
		mg_spc ? {r26_r[7:2], wd[1], r26_r[0]} : sw_i.wdata;
	wire r26_we = mg_cab | mg_spc | sw26;
	wire [7:0] r26_base = (r26_we ? r26_wr : r26_r) & `R26_MASK;
	wire cab_clr = stat_i.cable_done & ~(r26_we & r26_wr[`R26_CABLE]); // Self-clear
	wire [7:0] r26_nxt = r26_base & ~(8'(cab_clr) << `R26_CABLE);
	wire alt_nxt = mg_ctl ? wd[5] : sw31 ? sw_i.wdata[7] : alt_r;

	// Storage
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r26_r <= `RST_R26;
			r28_r <= `RST_R28;
			r29_r <= `RST_R29;
			alt_r <= `RST_ALT;
		end else begin
			r26_r <= r26_nxt;
			r28_r <= r28_nxt;
			r29_r <= r29_nxt;
			alt_r <= alt_nxt;
		end
	end

	// Management views; unimplemented bits read zero
	wire [15:0] v_ctl = {1'b0, r29_r[0], r28_r[6], r28_r[7], r29_r[3], 1'b0, r29_r[5], r28_r[5],
		2'b00, alt_r, r29_r[1], r29_r[2], r29_r[4], r29_r[6], r29_r[7]};
	wire [15:0] v_sts = {1'b0, 4'hf, 4'h0, 1'b0, stat_i.neg_done, stat_i.far_fault,
		r28_r[`R28_NEG_EN], stat_i.link_up, 2'b00};
	wire [15:0] v_adv = {5'h00, r28_r[4], 1'b0, r28_r[3:0], 5'h01};
	wire [15:0] v_prt = {5'h00, stat_i.partner[4], 1'b0, stat_i.partner[3:0], 5'h00};
	wire [15:0] v_cab = {r26_r[`R26_CABLE], stat_i.cable_result, stat_i.cable_short, 3'h0, stat_i.cable_count};
	wire [15:0] v_spc = {14'h0000, r26_r[`R26_NEAR], 1'b0};
	assign mg_rdata_o = (mg_i.idx == `IDX_CTRL) ? v_ctl : (mg_i.idx == `IDX_STAT) ? v_sts :
		(mg_i.idx == `IDX_IDH) ? ID_HIGH : (mg_i.idx == `IDX_IDL) ? ID_LOW :
		(mg_i.idx == `IDX_ADV) ? v_adv : (mg_i.idx == `IDX_PART) ? v_prt :
		(mg_i.idx == `IDX_CABLE) ? v_cab : (mg_i.idx == `IDX_SPEC) ? v_spc : 16'h0000;

	// Switch-side views
	wire [7:0] v26 = {stat_i.cable_short, stat_i.cable_result, r26_r[4], 2'b00, r26_r[1], stat_i.cable_count[8]};
	wire [7:0] v30 = {1'b0, stat_i.neg_done, stat_i.link_up, stat_i.partner};
	assign sw_rdata_o = (sw_i.idx == `SW_R26) ? v26 : (sw_i.idx == `SW_R27) ? stat_i.cable_count[7:0] :
		(sw_i.idx == `SW_R28) ? r28_r : (sw_i.idx == `SW_R29) ? r29_r :
		(sw_i.idx == `SW_R30) ? v30 : (sw_i.idx == `SW_R31) ? {alt_r, 6'h00, stat_i.far_fault} : 8'h00;

	// Controls toward the PHY core
	assign ctrl_o = '{force_100: r28_r[`R28_F100], negotiation_enable: r28_r[`R28_NEG_EN],
		power_down: r29_r[3], negotiation_restart: r29_r[`R29_RESTART],
		full_duplex: r28_r[`R28_FDUP], alt_crossover_algorithm: alt_r,
		force_straight_wiring: r29_r[1], crossover_off: r29_r[2], far_fault_off: r29_r[4],
		tx_off: r29_r[6], led_off: r29_r[7], far_loop: r29_r[0], near_loop: r26_r[`R26_NEAR],
		cable_start: r26_r[`R26_CABLE], advertise: r28_r[4:0]};
endmodule : port_phy_regs

/* hw/phy_mgmt_loopback_regs.sv */
// Management slave and loopback steering for two copper ports.
// Assumes management pins are asynchronous to clk_i; switch-side
// access, PHY status and symbol streams are on clk_i.
`include "phy_mgmt_regs.svh"
module phy_mgmt_loopback_regs
	import phy_mgmt_pkg::*;
(
	input wire logic clk_i, // System clock, 250 MHz
	input wire logic rst_b_i, // Asynchronous reset, low
	input wire logic mdc_i, // Management clock pin
	input wire logic mdio_i, // Management data in
	output logic mdio_o, // Management data out
	output logic mdio_oe_o, // Management data drive enable
	input wire sw_bus_type sw_i, // Switch-side byte access
	output logic [7:0] sw_rdata_o, // Switch-side read byte
	input wire phy_stat_type [1:0] stat_i, // PHY core status
	output phy_ctrl_type [1:0] ctrl_o, // PHY core controls
	input wire logic [1:0][4:0] rx_sym_i, // Line receive symbols
	input wire logic [1:0][4:0] mac_sym_i, // Normal transmit symbols
	output logic [1:0][4:0] tx_sym_o // Line transmit symbols
);

	// ********************************
	// Pin sampling
	// ********************************

	logic mdc_q; // Filtered clock level
	logic mdio_q; // Filtered data level
	logic mdc_d_r; // Previous clock level
	wire rise = mdc_q & ~mdc_d_r; // Clock rising edge seen

	// Both pins through one three-stage chain
	pin_sync3 #(
		.W(2)
	) u_pins (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i({mdc_i, mdio_i}),
		.q_o({mdc_q, mdio_q})
	);

	// Edge history
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mdc_d_r <= 1'b0;
		end else begin
			mdc_d_r <= mdc_q;
		end
	end

	// ********************************
	// Global address register
	// ********************************

	logic [7:0] global_r; // Address base and other global bits
	logic [7:0] global_nxt;
	wire [4:0] addr1 = global_r[7:`GLB_ADDR_LSB]; // First port address
	wire [4:0] addr2 = 5'(addr1 + 5'd1); // Second port follows
	wire glb_we = sw_i.wr && (sw_i.addr == `SW_GLOBAL);
	assign global_nxt = glb_we ? sw_i.wdata : global_r;

	// Reset gives addresses 1 and 2
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			global_r <= `RST_GLOBAL;
		end else begin
			global_r <= global_nxt;
		end
	end

	// ********************************
	// Frame walker
	// ********************************

	frame_state_type state_r; // Current frame field
	frame_state_type state_nxt;
	logic [5:0] pre_cnt_r; // Consecutive preamble ones
	logic [5:0] pre_nxt;
	logic [3:0] bit_cnt_r; // Bit within field
	logic [3:0] bit_nxt;
	logic [1:0] op_r; // Frame operation
	logic [1:0] op_nxt;
	logic [4:0] phy_r; // Port address of frame
	logic [4:0] phy_nxt;
	logic [4:0] reg_r; // Register index of frame
	logic [4:0] reg_nxt;
	logic [15:0] shf_r; // Shift in and shift out
	logic [15:0] shf_nxt;
	logic mo_r; // Driven data bit
	logic mo_nxt;
	logic moe_r; // Drive enable
	logic moe_nxt;

	// Shared decode
	wire [15:0] shf_in = {shf_r[14:0], mdio_q}; // Sample appended
	wire [4:0] live_idx = shf_in[4:0]; // Index while it arrives
	wire hit1 = (phy_r == addr1); // Frame for first port
	wire hit2 = (phy_r == addr2); // Frame for second port
	wire [4:0] mg_idx = (state_r == FR_REGADDR) ? live_idx : reg_r;
	wire [1:0][15:0] port_rdata; // Views from the slices
	wire [15:0] rd_word = hit1 ? port_rdata[0] : hit2 ? port_rdata[1] : 16'h0000;
	wire last_wr = rise && (state_r == FR_WDATA) && (bit_cnt_r == 4'hf);
	wire [3:0] bit_inc = 4'(bit_cnt_r + 4'd1);

	// Next field on each sampled clock rise
	always_comb begin
		state_nxt = state_r;
		pre_nxt = pre_cnt_r;
		bit_nxt = bit_cnt_r;
		op_nxt = op_r;
		phy_nxt = phy_r;
		reg_nxt = reg_r;
		shf_nxt = shf_r;
		mo_nxt = mo_r;
		moe_nxt = moe_r;
		if (rise) begin
			unique case (state_r)
				FR_PREAMBLE: begin
					// Count ones; a zero after a full preamble starts
					if (mdio_q) begin
						pre_nxt = (pre_cnt_r == `PRE_LEN) ? pre_cnt_r : 6'(pre_cnt_r + 6'd1);
					end else begin
						if (pre_cnt_r == `PRE_LEN) begin
							state_nxt = FR_START;
						end
						pre_nxt = 6'd0;
					end
				end
				FR_START: begin
					// Second start bit must be one
					state_nxt = mdio_q ? FR_OPCODE : FR_PREAMBLE;
					bit_nxt = 4'd0;
				end
				FR_OPCODE: begin
					// Two operation bits
					shf_nxt = shf_in;
					bit_nxt = bit_inc;
					if (bit_cnt_r == 4'd1) begin
						bit_nxt = 4'd0;
						op_nxt = shf_in[1:0];
						if ((shf_in[1:0] == `OP_RD) || (shf_in[1:0] == `OP_WR)) begin
							state_nxt = FR_PHYADDR;
						end else begin
							state_nxt = FR_PREAMBLE;
						end
					end
				end
				FR_PHYADDR: begin
					// Five address bits
					shf_nxt = shf_in;
					bit_nxt = bit_inc;
					if (bit_cnt_r == 4'd4) begin
						bit_nxt = 4'd0;
						phy_nxt = shf_in[4:0];
						state_nxt = FR_REGADDR;
					end
				end
				FR_REGADDR: begin
					// Five index bits; reads capture their word here
					shf_nxt = shf_in;
					bit_nxt = bit_inc;
					if (bit_cnt_r == 4'd4) begin
						bit_nxt = 4'd0;
						reg_nxt = live_idx;
						state_nxt = FR_TURN;
						if (op_r == `OP_RD) begin
							shf_nxt = rd_word;
						end
					end
				end
				FR_TURN: begin
					// Reads release then drive zero; writes skip two bits
					bit_nxt = bit_inc;
					if (op_r == `OP_RD) begin
						if (bit_cnt_r == 4'd0) begin
							moe_nxt = 1'b1;
							mo_nxt = 1'b0;
						end else begin
							mo_nxt = shf_r[15];
							shf_nxt = {shf_r[14:0], 1'b0};
							bit_nxt = 4'd0;
							state_nxt = FR_RDATA;
						end
					end else if (bit_cnt_r == 4'd1) begin
						bit_nxt = 4'd0;
						state_nxt = FR_WDATA;
					end
				end
				FR_RDATA: begin
					// Fifteen more bits, then release the line
					bit_nxt = bit_inc;
					mo_nxt = shf_r[15];
					shf_nxt = {shf_r[14:0], 1'b0};
					if (bit_cnt_r == 4'hf) begin
						mo_nxt = 1'b0;
						moe_nxt = 1'b0;
						bit_nxt = 4'd0;
						state_nxt = FR_PREAMBLE;
					end
				end
				FR_WDATA: begin
					// Sixteen data bits; commit on the last
					shf_nxt = shf_in;
					bit_nxt = bit_inc;
					if (bit_cnt_r == 4'hf) begin
						bit_nxt = 4'd0;
						state_nxt = FR_PREAMBLE;
					end
				end
			endcase
		end
	end

	// Frame registers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= FR_PREAMBLE;
			pre_cnt_r <= 6'd0;
			bit_cnt_r <= 4'd0;
			op_r <= 2'b00;
			phy_r <= 5'h00;
			reg_r <= 5'h00;
			shf_r <= 16'h0000;
			mo_r <= 1'b0;
			moe_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pre_cnt_r <= pre_nxt;
			bit_cnt_r <= bit_nxt;
			op_r <= op_nxt;
			phy_r <= phy_nxt;
			reg_r <= reg_nxt;
			shf_r <= shf_nxt;
			mo_r <= mo_nxt;
			moe_r <= moe_nxt;
		end
	end

	assign mdio_o = mo_r;
	assign mdio_oe_o = moe_r;

	// ********************************
	// Switch-side decode
	// ********************************

	// Port windows of six bytes each
	wire in1 = (sw_i.addr >= `SW_P1_BASE) && (sw_i.addr < 8'(`SW_P1_BASE + `SW_SPAN));
	wire in2 = (sw_i.addr >= `SW_P2_BASE) && (sw_i.addr < 8'(`SW_P2_BASE + `SW_SPAN));
	wire [2:0] idx1 = 3'(sw_i.addr - `SW_P1_BASE);
	wire [2:0] idx2 = 3'(sw_i.addr - `SW_P2_BASE);
	wire [1:0][7:0] port_sw_rdata; // Bytes from the slices
	wire [7:0] sw_rd_nxt = glb_we ? sw_i.wdata : (sw_i.addr == `SW_GLOBAL) ? global_r :
		in1 ? port_sw_rdata[0] : in2 ? port_sw_rdata[1] : 8'h00;

	// Read byte one cycle after the address
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sw_rdata_o <= 8'h00;
		end else begin
			sw_rdata_o <= sw_rd_nxt;
		end
	end

	// ********************************
	// Port slices and loopback
	// ********************************

	logic [1:0][4:0] far_path_r; // Stream turned at this port's coding layer
	logic [1:0][4:0] tx_nxt;

	for (genvar p = 0; p < 2; p++) begin : g_port
		localparam int O = 1 - p; // Other port
		wire hit = (p == 0) ? hit1 : hit2;
		wire mgmt_req_type mreq = '{wr: last_wr && hit, idx: mg_idx, wdata: shf_in};
		wire sw_req_type sreq = '{wr: sw_i.wr && ((p == 0) ? in1 : in2),
			idx: (p == 0) ? idx1 : idx2, wdata: sw_i.wdata};

		// One slice per copper port
		port_phy_regs u_regs (
			.clk_i(clk_i),
			.rst_b_i(rst_b_i),
			.mg_i(mreq),
			.sw_i(sreq),
			.stat_i(stat_i[p]),
			.mg_rdata_o(port_rdata[p]),
			.sw_rdata_o(port_sw_rdata[p]),
			.ctrl_o(ctrl_o[p])
		);

		// Near loop beats far loop; transmit disable beats both
		assign tx_nxt[p] = ctrl_o[p].tx_off ? 5'h00 :
			ctrl_o[p].near_loop ? rx_sym_i[p] :
			ctrl_o[O].far_loop ? far_path_r[O] : mac_sym_i[p];

		// Other port's receive stream wraps here
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				far_path_r[p] <= 5'h00;
				tx_sym_o[p] <= 5'h00;
			end else begin
				far_path_r[p] <= rx_sym_i[O];
				tx_sym_o[p] <= tx_nxt[p];
			end
		end
	end

endmodule : phy_mgmt_loopback_regs

/* dv/phy_mgmt_loopback_regs_assertions.sv */
// Checker for the management bank and loopback steering.
// Assumes it is bound to the top module and sees only its ports.
module phy_mgmt_checker
	import phy_mgmt_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire sw_bus_type sw_i,
	input wire phy_stat_type [1:0] stat_i,
	input wire phy_ctrl_type [1:0] ctrl_o,
	input wire logic [1:0][4:0] rx_sym_i,
	input wire logic [1:0][4:0] mac_sym_i,
	input wire logic [1:0][4:0] tx_sym_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// ****************************************
	// Switch write decodes
	// ****************************************
	wire logic w1c = sw_i.wr && sw_i.addr == 8'h1c; // Port 1 byte 28
	wire logic w1d = sw_i.wr && sw_i.addr == 8'h1d; // Port 1 byte 29
	wire logic w2d = sw_i.wr && sw_i.addr == 8'h2d; // Port 2 byte 45
	// ****************************************
	// Properties
	// ****************************************
	// Port 1 far loop returns port 2 receive on port 2 transmit
	property p_far;
		$past(ctrl_o[0].far_loop && !ctrl_o[1].near_loop && !ctrl_o[1].tx_off) |-> tx_sym_o[1] == $past(rx_sym_i[1], 2);
	endproperty
	a_far: assert property (p_far) else $error("far loop symbols wrong");
	// Near loop turns receive around on the same port
	property p_near;
		$past(ctrl_o[1].near_loop && !ctrl_o[1].tx_off) |-> tx_sym_o[1] == $past(rx_sym_i[1]);
	endproperty
	a_near: assert property (p_near) else $error("near loop symbols wrong");
	// Normal path carries transmit symbols
	property p_mac;
		$past(rst_b_i && !ctrl_o[0].tx_off && !ctrl_o[0].near_loop && !ctrl_o[1].far_loop) |->
			tx_sym_o[0] == $past(mac_sym_i[0]);
	endproperty
	a_mac: assert property (p_mac) else $error("normal symbols wrong");
	// Disabled transmitter sends nothing
	property p_txoff;
		$past(ctrl_o[0].tx_off) |-> tx_sym_o[0] == 5'h00;
	endproperty
	a_txoff: assert property (p_txoff) else $error("transmit not silenced");
	// Far loop and power down share byte 29
	property p_fbit;
		w1d |=> ctrl_o[0].far_loop == $past(sw_i.wdata[0]) && ctrl_o[0].power_down == $past(sw_i.wdata[3]);
	endproperty
	a_fbit: assert property (p_fbit) else $error("byte 29 not shared");
	// Near loop control in byte 42
	property p_nbit;
		sw_i.wr && sw_i.addr == 8'h2a |=> ctrl_o[1].near_loop == $past(sw_i.wdata[1]);
	endproperty
	a_nbit: assert property (p_nbit) else $error("byte 42 near bit lost");
	// Speed, negotiation and duplex in byte 28
	property p_speed;
		w1c |=> {ctrl_o[0].negotiation_enable, ctrl_o[0].force_100, ctrl_o[0].full_duplex} == $past(sw_i.wdata[7:5]);
	endproperty
	a_speed: assert property (p_speed) else $error("byte 28 controls wrong");
	// Crossover algorithm in byte 47
	property p_alt;
		sw_i.wr && sw_i.addr == 8'h2f |=> ctrl_o[1].alt_crossover_algorithm == $past(sw_i.wdata[7]);
	endproperty
	a_alt: assert property (p_alt) else $error("byte 47 algorithm wrong");
	// Wiring, fault, transmit and LED disables in byte 45
	property p_wire;
		w2d |=> {ctrl_o[1].led_off, ctrl_o[1].tx_off, ctrl_o[1].far_fault_off, ctrl_o[1].crossover_off,
			ctrl_o[1].force_straight_wiring} == $past({sw_i.wdata[7:6], sw_i.wdata[4], sw_i.wdata[2:1]});
	endproperty
	a_wire: assert property (p_wire) else $error("byte 45 controls wrong");
	// Restart request drops once restart has begun
	property p_restart;
		ctrl_o[0].negotiation_restart && stat_i[0].restart_begun && !sw_i.wr |=> !ctrl_o[0].negotiation_restart;
	endproperty
	a_restart: assert property (p_restart) else $error("restart not cleared");
	// Main scenarios reached
	c_far: cover property (ctrl_o[0].far_loop);
	c_near: cover property (ctrl_o[1].near_loop);
	c_restart: cover property (ctrl_o[0].negotiation_restart && stat_i[0].restart_begun);
endmodule : phy_mgmt_checker

bind phy_mgmt_loopback_regs phy_mgmt_checker i_phy_mgmt_checker (.clk_i, .rst_b_i, .sw_i, .stat_i, .ctrl_o,
	.rx_sym_i, .mac_sym_i, .tx_sym_o);

/* dv/mgmt_station.sv */
// Management station model: drives frames on the serial pins.
// Assumes the bench resolves the data line with a pull-up.
module mgmt_station (
	output logic mdc_o, // Link clock, low outside frames
	output logic mdio_o, // Data toward the device
	output logic mdio_oe_o, // High while the station drives
	input wire logic mdio_i // Resolved data line
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle: clock still, line released
	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b0;
		mdio_oe_o = 1'b0;
	end
	// One full frame; read data sampled on rising edges
	task automatic frame(input logic wr, input logic [4:0] pa, input logic [4:0] ri, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [63:0] bits;
		bits = {32'hffff_ffff, 2'b01, wr ? 2'b01 : 2'b10, pa, ri, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 0; i < 64; i++) begin
			mdio_oe_o = wr || i < 46; // Release at turnaround on reads
			mdio_o = bits[63 - i];
			#62.5 mdc_o = 1'b1;
			if (i >= 48) begin
				rd = {rd[14:0], mdio_i};
			end
			#62.5 mdc_o = 1'b0;
		end
		mdio_oe_o = 1'b0;
	endtask : frame
endmodule : mgmt_station

/* dv/phy_mgmt_loopback_regs_bench.sv */
// Self-checking bench for the management bank and loopback steering.
// Assumes the design package and the station model are compiled first.
module phy_mgmt_loopback_regs_bench;
	import phy_mgmt_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	`define CHK(n, e, g) if ((g) !== (e)) begin failures++; $display("wrong value %s exp %h got %h", n, e, g); end
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	sw_bus_type sw = '0;
	phy_stat_type [1:0] st = '0;
	logic [1:0][4:0] rx = '0;
	logic [1:0][4:0] mac = '0;
	logic [1:0][4:0] tx;
	phy_ctrl_type [1:0] ctrl;
	logic [7:0] srdata;
	logic mdc, st_d, st_oe, dv_d, dv_oe;
	wire logic line = dv_oe ? dv_d : (st_oe ? st_d : 1'b1); // Pull-up when released
	logic [15:0] exp_q[$];
	string nm_q[$];
	logic [15:0] got, exp_w;
	string nm_w;
	event seen;
	int failures = 0;
	int tests_run = 0;
	// ****************************************
	// Clock, design and station
	// ****************************************
	always #2 clk_i = ~clk_i;
	phy_mgmt_loopback_regs i_phy_mgmt_loopback_regs (.clk_i(clk_i), .rst_b_i(rst_b_i), .mdc_i(mdc), .mdio_i(line),
		.mdio_o(dv_d), .mdio_oe_o(dv_oe), .sw_i(sw), .sw_rdata_o(srdata), .stat_i(st), .ctrl_o(ctrl),
		.rx_sym_i(rx), .mac_sym_i(mac), .tx_sym_o(tx));
	mgmt_station i_mgmt_station (.mdc_o(mdc), .mdio_o(st_d), .mdio_oe_o(st_oe), .mdio_i(line));
	// Random symbol streams
	always @(negedge clk_i) begin
		rx <= 10'($urandom);
		mac <= 10'($urandom);
	end
	// ****************************************
	// Result watcher and tasks
	// ****************************************
	initial forever begin
		@(seen);
		tests_run++;
		exp_w = exp_q.pop_front();
		nm_w = nm_q.pop_front();
		`CHK(nm_w, exp_w, got)
	end
	task automatic note(input string n, input logic [15:0] e);
		exp_q.push_back(e);
		nm_q.push_back(n);
	endtask : note
	task automatic mrd(input logic [4:0] pa, input logic [4:0] ri, input logic [15:0] e);
		logic [15:0] r;
		note($sformatf("mgmt %0d.%0h", pa, ri), e);
		i_mgmt_station.frame(1'b0, pa, ri, 16'h0000, r);
		got = r;
		->seen;
	endtask : mrd
	task automatic mwr(input logic [4:0] pa, input logic [4:0] ri, input logic [15:0] d);
		logic [15:0] r;
		i_mgmt_station.frame(1'b1, pa, ri, d, r);
		repeat (8) @(negedge clk_i); // Commit lands a few clocks after the last edge
	endtask : mwr
	task automatic swr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		sw <= '{wr: 1'b1, addr: a, wdata: d};
		@(negedge clk_i);
		sw.wr <= 1'b0;
	endtask : swr
	task automatic srd(input logic [7:0] a, input logic [7:0] e);
		note($sformatf("byte %h", a), {8'h00, e});
		@(negedge clk_i);
		sw <= '{wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge clk_i);
		got = {8'h00, srdata};
		->seen;
	endtask : srd
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		void'($urandom(69366));
		repeat (10) @(negedge clk_i);
		rst_b_i = 1'b1;
		repeat (8) @(negedge clk_i);
		srd(8'h0f, 8'h08);
		srd(8'h1f, 8'h80);
		srd(8'h40, 8'h00);
		mrd(5'd1, 5'h00, 16'h1020);
		mrd(5'd2, 5'h01, 16'h7808);
		mrd(5'd1, 5'h06, 16'h0000);
		mrd(5'd2, 5'h1e, 16'h0000);
		mrd(5'd3, 5'h00, 16'h0000);
		$display("test reset values done");
		mwr(5'd1, 5'h00, 16'hffff);
		mrd(5'd1, 5'h00, 16'h7b3f);
		srd(8'h1d, 8'hff);
		@(negedge clk_i);
		st[0].restart_begun <= 1'b1;
		@(negedge clk_i);
		st[0].restart_begun <= 1'b0;
		srd(8'h1d, 8'hdf);
		$display("test control bits done");
		mwr(5'd1, 5'h00, 16'h2000);
		mwr(5'd2, 5'h00, 16'h2000);
		swr(8'h1d, 8'h01);
		mrd(5'd1, 5'h00, 16'h6000);
		mwr(5'd2, 5'h1f, 16'h0002);
		srd(8'h2a, 8'h02);
		swr(8'h2a, 8'h00);
		swr(8'h2f, 8'h80);
		mrd(5'd2, 5'h00, 16'h2020);
		$display("test loopback done");
		swr(8'h0f, 8'h28);
		@(negedge clk_i);
		st[0].neg_done <= 1'b1;
		st[0].link_up <= 1'b1;
		st[0].far_fault <= 1'b1;
		mrd(5'd5, 5'h01, 16'h7834);
		mrd(5'd1, 5'h00, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			swr(8'h2d, 8'($urandom));
			swr(8'h1c, 8'($urandom));
		end
		$display("test address and status done");
		print_verdict();
	end
	// Watchdog well beyond the expected run
	initial begin
		#300us;
		failures++;
		print_verdict();
	end
endmodule : phy_mgmt_loopback_regs_bench
